// [hdl/spm_monitors.sv]
// protection timers, monitors and interrupt acknowledge logic
`include "spm_cfg.svh"
// Function
// - periodic timer uses an 8-bit down counter loaded from the count field
// - timer clock is reference, optionally divided by 512, then always by 4
// - prescaler bits are software settable so both prescalers can be enabled
// - counter reaching zero raises periodic interrupt at programmed level
// - acknowledge of periodic interrupt returns the programmed periodic vector
// - after service the count field is reloaded and counting resumes
// - a new nonzero count takes effect only at reload after service; writing zero stops the timer at once
// - software can disable the periodic timer completely
// - requests with arbitration priority zero are discarded
// - same-level requests arbitrate by priority during acknowledge
// - eight mastership levels; unit above all, core below, transfer engine not 0 or 7
// - levels set in autovector register get an autovector from this unit for external requests
// - two show-cycle bits enable show cycles and select arbitration
// - bus monitor times cycle termination and flags bus error on overrun
// - internal cycles always watched; external only if enabled and master
// - monitor limit programmable from 64 to 512 clocks
// - halt with enable resets system and records double-fault cause
// - acknowledge with no arbitration gives bus error, always on
// - enabled watchdog timeout gives reset or level 7 interrupt by select bit
// - watchdog vector from its register; rate from prescale bit and timing field
// - same-level priority watchdog, periodic timer, external
// - external limit chosen from four values
module spm_monitors
  import spm_pkg::*;
#(
  parameter int WDT_BASE_LOG = 9
) (
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  // register port
  input  wire logic [2:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  // interrupt requests and acknowledge
  input  wire logic [7:1]  EXT_IRQ_I,
  input  wire logic        INTERRUPT_ACKNOWLEDGE_CYCLE_I,
  input  wire logic [2:0]  INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_I,
  input  wire logic        PEER_ARB_I,
  input  wire logic [3:0]  PEER_ARBITRATION_PRIORITY_FIELD_I,
  output logic      [2:0]  IRQ_LEVEL_O,
  output spm_ack_t         ACK_O,
  // bus cycle monitor
  input  spm_cyc_t         BUS_CYC_I,
  output logic             BUS_ERR_O,
  // double fault and reset
  input  wire logic        HALT_I,
  output logic             SYS_RESET_O,
  // show cycles and mastership
  output logic             SHOW_EN_O,
  output logic             SHOW_ARB_EN_O,
  input  wire logic        UNIT_BREQ_I,
  input  wire logic        DMA_BREQ_I,
  input  wire logic        CORE_BREQ_I,
  output logic      [2:0]  GRANT_O
);
  logic [15:0] cfg_reg, cfg_next, avs_reg, avs_next, prot_reg, prot_next;
  logic [15:0] pic_reg, pic_next, ptr_reg, ptr_next, wvec_reg, wvec_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [1:0]  rcs_reg, rcs_next;
  logic [8:0]  pre_reg, pre_next;
  logic [1:0]  div_reg, div_next;
  logic [7:0]  pit_cnt_reg, pit_cnt_next;
  spm_pit_t    pit_reg, pit_next;
  logic        pit_pend_reg, pit_pend_next;
  spm_svc_t    svc_reg, svc_next;
  logic [15:0] wdt_cnt_reg, wdt_cnt_next;
  logic        wdt_pend_reg, wdt_pend_next;
  logic        rst_reg, rst_next, halt_reg, halt_next;
  logic [2:0]  lvl_reg, lvl_next;
  spm_ack_t    ack_reg, ack_next;
  logic [9:0]  mon_cnt_reg, mon_cnt_next;
  logic        mon_hit_reg, mon_hit_next, berr_reg, berr_next;
  logic        pre_tick, pit_tick, wdt_tick, wdt_fire, kick, pit_svc, wdt_svc;
  logic        halt_fire, win, own, watched;
  logic [15:0] wdt_lim;
  logic [9:0]  mon_lim;
  logic [3:0]  arbitration_priority_field;
  logic [2:0]  periodic_irq_level;

  // field views
  assign arbitration_priority_field  = cfg_reg[3:0];
  assign periodic_irq_level = pic_reg[10:8];

  // register writes and read data
  always_comb begin
    cfg_next  = cfg_reg;
    avs_next  = avs_reg;
    prot_next = prot_reg;
    pic_next  = pic_reg;
    ptr_next  = ptr_reg;
    wvec_next = wvec_reg;
    rdata_next = 16'h0000;
    if (WR_I) begin
      case (ADDR_I)
        `SPM_OFS_CFG:  cfg_next  = WDATA_I & `SPM_CFG_MASK;
        `SPM_OFS_AVS:  avs_next  = WDATA_I & `SPM_AVS_MASK;
        `SPM_OFS_PROT: prot_next = WDATA_I & `SPM_PROT_MASK;
        `SPM_OFS_PIC:  pic_next  = WDATA_I & `SPM_PIC_MASK;
        `SPM_OFS_PTR:  ptr_next  = WDATA_I & `SPM_PTR_MASK;
        `SPM_OFS_WVEC: wvec_next = WDATA_I & `SPM_WVEC_MASK;
        default: ;
      endcase
    end
    if (RD_I) begin
      case (ADDR_I)
        `SPM_OFS_CFG:  rdata_next = cfg_reg;
        `SPM_OFS_AVS:  rdata_next = avs_reg;
        `SPM_OFS_PROT: rdata_next = prot_reg;
        `SPM_OFS_PIC:  rdata_next = pic_reg;
        `SPM_OFS_PTR:  rdata_next = ptr_reg;
        `SPM_OFS_WVEC: rdata_next = wvec_reg;
        `SPM_OFS_RCS:  rdata_next = {14'h0000, rcs_reg};
        default:       rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_reg   <= `SPM_CFG_RST;
      avs_reg   <= `SPM_AVS_RST;
      prot_reg  <= `SPM_PROT_RST;
      pic_reg   <= `SPM_PIC_RST;
      ptr_reg   <= `SPM_PTR_RST;
      wvec_reg  <= `SPM_WVEC_RST;
      rdata_reg <= 16'h0000;
    end else begin
      cfg_reg   <= cfg_next;
      avs_reg   <= avs_next;
      prot_reg  <= prot_next;
      pic_reg   <= pic_next;
      ptr_reg   <= ptr_next;
      wvec_reg  <= wvec_next;
      rdata_reg <= rdata_next;
    end
  end
  assign RDATA_O = rdata_reg;

  // shared 512 prescaler and the divide by 4 stage
  assign pre_tick = (pre_reg == `SPM_PRE_LAST);
  assign pit_tick = (div_reg == `SPM_DIV_LAST) && (pre_tick || !ptr_reg[`SPM_PTR_TPS]);
  assign wdt_tick = pre_tick || !ptr_reg[`SPM_PTR_WPS];

  // periodic timer: counts down, waits for service, reloads
  always_comb begin
    pre_next = pre_reg + 9'h001;
    div_next = div_reg;
    if (pre_tick || !ptr_reg[`SPM_PTR_TPS]) begin
      div_next = div_reg + 2'h1;
    end
    pit_next      = pit_reg;
    pit_cnt_next  = pit_cnt_reg;
    pit_pend_next = pit_pend_reg && !pit_svc;
    case (pit_reg)
      PT_OFF: begin
        if (ptr_reg[7:0] != 8'h00) begin
          pit_cnt_next = ptr_reg[7:0];
          pit_next     = PT_RUN;
        end
      end
      PT_RUN: begin
        if (ptr_reg[7:0] == 8'h00) begin
          pit_next = PT_OFF;
        end else if (pit_tick) begin
          pit_cnt_next = pit_cnt_reg - 8'h01;
          if (pit_cnt_reg == 8'h01) begin
            pit_pend_next = 1'b1;
            pit_next      = PT_WAIT;
          end
        end
      end
      PT_WAIT: begin
        if (pit_svc) begin
          pit_cnt_next = ptr_reg[7:0];
          pit_next     = (ptr_reg[7:0] == 8'h00) ? PT_OFF : PT_RUN;
        end
      end
      default: pit_next = PT_OFF;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pre_reg      <= 9'h000;
      div_reg      <= 2'h0;
      pit_reg      <= PT_OFF;
      pit_cnt_reg  <= 8'h00;
      pit_pend_reg <= 1'b0;
    end else begin
      pre_reg      <= pre_next;
      div_reg      <= div_next;
      pit_reg      <= pit_next;
      pit_cnt_reg  <= pit_cnt_next;
      pit_pend_reg <= pit_pend_next;
    end
  end

  // watchdog period and events
  assign wdt_lim = 16'((32'd1 << (WDT_BASE_LOG + 2 * int'(prot_reg[5:4]))) - 1);
  assign wdt_fire = prot_reg[`SPM_PROT_WEN] && wdt_tick && (wdt_cnt_reg >= wdt_lim);
  assign kick = WR_I && (ADDR_I == `SPM_OFS_WSV) && (WDATA_I[7:0] == `SPM_SVC_KICK)
                && (svc_reg == SV_ARMED);
  assign halt_fire = HALT_I && !halt_reg && prot_reg[`SPM_PROT_DFE];

  // watchdog service sequence, counter, reset and cause
  always_comb begin
    svc_next = svc_reg;
    case (svc_reg)
      SV_IDLE: begin
        if (WR_I && (ADDR_I == `SPM_OFS_WSV) && (WDATA_I[7:0] == `SPM_SVC_ARM)) begin
          svc_next = SV_ARMED;
        end
      end
      SV_ARMED: begin
        if (kick) begin
          svc_next = SV_IDLE;
        end
      end
      default: svc_next = SV_IDLE;
    endcase
    wdt_cnt_next = wdt_cnt_reg;
    if (!prot_reg[`SPM_PROT_WEN] || kick || wdt_fire) begin
      wdt_cnt_next = 16'h0000;
    end else if (wdt_tick) begin
      wdt_cnt_next = wdt_cnt_reg + 16'h0001;
    end
    wdt_pend_next = (wdt_pend_reg && !wdt_svc)
                    || (wdt_fire && !prot_reg[`SPM_PROT_WRI]);
    rst_next  = halt_fire || (wdt_fire && prot_reg[`SPM_PROT_WRI]);
    halt_next = HALT_I;
    rcs_next  = rcs_reg;
    if (rst_next) begin
      rcs_next = {halt_fire, !halt_fire};
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      svc_reg      <= SV_IDLE;
      wdt_cnt_reg  <= 16'h0000;
      wdt_pend_reg <= 1'b0;
      rst_reg      <= 1'b0;
      halt_reg     <= 1'b0;
      rcs_reg      <= 2'h0;
    end else begin
      svc_reg      <= svc_next;
      wdt_cnt_reg  <= wdt_cnt_next;
      wdt_pend_reg <= wdt_pend_next;
      rst_reg      <= rst_next;
      halt_reg     <= halt_next;
      rcs_reg      <= rcs_next;
    end
  end
  assign SYS_RESET_O = rst_reg;

  // acknowledge arbitration: priority compare, then source order
  assign win = (arbitration_priority_field != 4'h0) && (!PEER_ARB_I || (arbitration_priority_field > PEER_ARBITRATION_PRIORITY_FIELD_I));
  assign own = (wdt_pend_reg && (INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_I == `SPM_WDT_LVL))
               || (pit_pend_reg && (periodic_irq_level == INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_I))
               || ((INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_I != 3'h0) && EXT_IRQ_I[INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_I]);
  assign wdt_svc = INTERRUPT_ACKNOWLEDGE_CYCLE_I && win && wdt_pend_reg && (INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_I == `SPM_WDT_LVL);
  assign pit_svc = INTERRUPT_ACKNOWLEDGE_CYCLE_I && win && !wdt_svc && pit_pend_reg
                   && (periodic_irq_level == INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_I);

  // pending level and acknowledge answer
  always_comb begin
    lvl_next = 3'h0;
    for (int l = 1; l < 8; l++) begin
      if (arbitration_priority_field != 4'h0 && (EXT_IRQ_I[l] || (pit_pend_reg && periodic_irq_level == 3'(l))
          || (wdt_pend_reg && 3'(l) == `SPM_WDT_LVL))) begin
        lvl_next = 3'(l);
      end
    end
    ack_next = '0;
    if (INTERRUPT_ACKNOWLEDGE_CYCLE_I) begin
      ack_next.valid = 1'b1;
      if (wdt_svc) begin
        ack_next.vector = wvec_reg[7:0];
      end else if (pit_svc) begin
        ack_next.vector = pic_reg[7:0];
      end else if (win && own && avs_reg[INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_I]) begin
        ack_next.autovec = 1'b1;
      end else if (win && own) begin
        ack_next.valid = 1'b0;
      end else if (!PEER_ARB_I) begin
        ack_next.berr = 1'b1;
      end else begin
        ack_next.valid = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lvl_reg <= 3'h0;
      ack_reg <= '0;
    end else begin
      lvl_reg <= lvl_next;
      ack_reg <= ack_next;
    end
  end
  assign IRQ_LEVEL_O = lvl_reg;
  assign ACK_O       = ack_reg;

  // bus monitor: count until termination, one error per cycle
  assign mon_lim = `SPM_MON_MIN << prot_reg[1:0];
  assign watched = BUS_CYC_I.active
                   && (!BUS_CYC_I.external
                       || (prot_reg[`SPM_PROT_MEE] && BUS_CYC_I.master));
  always_comb begin
    mon_cnt_next = mon_cnt_reg;
    mon_hit_next = mon_hit_reg;
    berr_next    = 1'b0;
    if (!BUS_CYC_I.active || BUS_CYC_I.done) begin
      mon_cnt_next = 10'h000;
      mon_hit_next = 1'b0;
    end else if (watched && !mon_hit_reg) begin
      if (mon_cnt_reg == mon_lim - 10'h001) begin
        berr_next    = 1'b1;
        mon_hit_next = 1'b1;
      end else begin
        mon_cnt_next = mon_cnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mon_cnt_reg <= 10'h000;
      mon_hit_reg <= 1'b0;
      berr_reg    <= 1'b0;
    end else begin
      mon_cnt_reg <= mon_cnt_next;
      mon_hit_reg <= mon_hit_next;
      berr_reg    <= berr_next;
    end
  end
  assign BUS_ERR_O = berr_reg;

  // show cycles and mastership grant
  assign SHOW_EN_O = cfg_reg[`SPM_CFG_SHHI] || cfg_reg[`SPM_CFG_SHLO];
  assign SHOW_ARB_EN_O = SHOW_EN_O && !cfg_reg[`SPM_CFG_SHHI];
  always_comb begin
    GRANT_O = 3'h0;
    if (UNIT_BREQ_I) begin
      GRANT_O = 3'h4;
    end else if (DMA_BREQ_I && cfg_reg[10:8] != 3'h0 && cfg_reg[10:8] != 3'h7) begin
      GRANT_O = 3'h2;
    end else if (CORE_BREQ_I) begin
      GRANT_O = 3'h1;
    end
  end

  // checks
  AST_PIT_IRQ: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    pit_reg == PT_RUN && pit_tick && pit_cnt_reg == 8'h01 && ptr_reg[7:0] != 8'h00
    |=> pit_pend_reg && pit_reg == PT_WAIT)
    else $error("periodic interrupt not raised at zero");
  AST_PIT_RELOAD: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    pit_reg == PT_WAIT && pit_svc |=> pit_cnt_reg == $past(ptr_reg[7:0]))
    else $error("count not reloaded after service");
  AST_PIT_VEC: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    pit_svc |=> ACK_O.valid && ACK_O.vector == $past(pic_reg[7:0]))
    else $error("periodic vector wrong");
  AST_DIV4: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    pit_tick |=> div_reg == 2'h0 && !pit_tick ##1 !pit_tick [*2])
    else $error("divide by four broken");
  AST_WDT_RST: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    wdt_fire && prot_reg[`SPM_PROT_WRI] && !halt_fire |=> SYS_RESET_O && rcs_reg == 2'h1)
    else $error("watchdog reset missing");
  AST_WDT_IRQ: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    wdt_fire && !prot_reg[`SPM_PROT_WRI] |=> wdt_pend_reg ##1 (lvl_reg == 3'h7 || arbitration_priority_field == 4'h0))
    else $error("watchdog interrupt missing");
  AST_KICK: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    kick |=> wdt_cnt_reg == 16'h0000 && svc_reg == SV_IDLE)
    else $error("service did not restart watchdog");
  AST_DBF: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    halt_fire |=> SYS_RESET_O && rcs_reg == 2'h2)
    else $error("double fault reset missing");
  AST_SPUR: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    INTERRUPT_ACKNOWLEDGE_CYCLE_I && !PEER_ARB_I && arbitration_priority_field == 4'h0 |=> ACK_O.valid && ACK_O.berr)
    else $error("spurious acknowledge not faulted");
  AST_MON: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    BUS_ERR_O |-> $past(mon_cnt_reg) == $past(mon_lim) - 10'h001)
    else $error("bus monitor limit wrong");
  AST_DMA: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    UNIT_BREQ_I || (cfg_reg[10:8] == 3'h0) |-> !GRANT_O[1])
    else $error("illegal transfer engine grant");
endmodule

// [hdl/spm_cfg.svh]
// offsets, fields, reset values and counts of the protection monitors
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
// register word offsets
`define SPM_OFS_CFG  3'h0
`define SPM_OFS_AVS  3'h1
`define SPM_OFS_PROT 3'h2
`define SPM_OFS_PIC  3'h3
`define SPM_OFS_PTR  3'h4
`define SPM_OFS_WSV  3'h5
`define SPM_OFS_WVEC 3'h6
`define SPM_OFS_RCS  3'h7
// writable bits of each register
`define SPM_CFG_MASK  16'h073f
`define SPM_AVS_MASK  16'h00fe
`define SPM_PROT_MASK 16'h00ff
`define SPM_PIC_MASK  16'h07ff
`define SPM_PTR_MASK  16'h03ff
`define SPM_WVEC_MASK 16'h00ff
// reset values
`define SPM_CFG_RST  16'h0000
`define SPM_AVS_RST  16'h0000
`define SPM_PROT_RST 16'h0000
`define SPM_PIC_RST  16'h000f
`define SPM_PTR_RST  16'h0000
`define SPM_WVEC_RST 16'h000f
// field positions
`define SPM_CFG_SHLO 4
`define SPM_CFG_SHHI 5
`define SPM_PROT_MEE 2
`define SPM_PROT_DFE 3
`define SPM_PROT_WRI 6
`define SPM_PROT_WEN 7
`define SPM_PTR_TPS  8
`define SPM_PTR_WPS  9
// service codes, levels and counts
`define SPM_SVC_ARM  8'h55
`define SPM_SVC_KICK 8'haa
`define SPM_WDT_LVL  3'h7
`define SPM_PRE_LAST 9'h1ff
`define SPM_DIV_LAST 2'h3
`define SPM_MON_MIN  10'h040
`endif

// [hdl/spm_pkg.sv]
// types of the protection monitors
package spm_pkg;
  typedef enum logic [1:0] {SV_IDLE = 2'b01, SV_ARMED = 2'b10} spm_svc_t;
  typedef enum logic [2:0] {PT_OFF = 3'b001, PT_RUN = 3'b010, PT_WAIT = 3'b100} spm_pit_t;
  typedef struct packed {
    logic       valid;
    logic       autovec;
    logic       berr;
    logic [7:0] vector;
  } spm_ack_t;
  typedef struct packed {
    logic active;
    logic external;
    logic master;
    logic done;
  } spm_cyc_t;
endpackage

// [sim/spm_core_model.sv]
// processor core model: runs interrupt acknowledge cycles on request
module spm_core_model
  import spm_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // request from the bench, lag in cycles
  input  wire logic       go_i,
  input  wire logic [2:0] lvl_i,
  input  wire logic [3:0] lag_i,
  // acknowledge bus
  input  spm_ack_t        ack_i,
  output logic            interrupt_acknowledge_cycle_o,
  output logic      [2:0] interrupt_acknowledge_cycle_lvl_o,
  // answer taken from the unit
  output spm_ack_t        got_o,
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // one strobe per request; the level is scrambled once no longer qualified
  initial begin
    interrupt_acknowledge_cycle_o = 1'b0;
    interrupt_acknowledge_cycle_lvl_o = 3'h0;
    got_o = '0;
    done_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1 && rst_n_i === 1'b1) begin
        repeat (lag_i) @(posedge clk_i);
        interrupt_acknowledge_cycle_o <= 1'b1;
        interrupt_acknowledge_cycle_lvl_o <= lvl_i;
        @(posedge clk_i);
        interrupt_acknowledge_cycle_o <= 1'b0;
        interrupt_acknowledge_cycle_lvl_o <= ~lvl_i;
        @(posedge clk_i);
        got_o <= ack_i;
        done_o <= 1'b1;
        @(posedge clk_i);
        done_o <= 1'b0;
      end
    end
  end
endmodule

// [sim/test_system_protection_monitors.sv]
// self-checking bench of the protection monitors
`include "spm_cfg.svh"
module test_system_protection_monitors
  import spm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // stimulus and observed signals
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [7:1]  ext_irq = 7'h00;
  logic        interrupt_acknowledge_cycle;
  logic [2:0]  interrupt_acknowledge_cycle_lvl;
  logic        peer_arb = 1'b0;
  logic [3:0]  peer_arbitration_priority_field = 4'h0;
  logic [2:0]  irq_lvl;
  spm_ack_t    ack;
  spm_cyc_t    cyc = '0;
  logic        bus_err;
  logic        halt = 1'b0;
  logic        sys_rst;
  logic        show_en;
  logic        show_arb;
  logic [2:0]  breq = 3'h0;
  logic [2:0]  grant;
  logic        go = 1'b0;
  logic [2:0]  go_lvl = 3'h0;
  logic [3:0]  lag = 4'h0;
  spm_ack_t    got;
  logic        done;
  logic [2:0]  want = 3'h0;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n = 0;
  // expected acknowledge answers
  localparam spm_ack_t SPUR = '{1'b1, 1'b0, 1'b1, 8'h00};
  localparam spm_ack_t AUTO = '{1'b1, 1'b1, 1'b0, 8'h00};
  localparam spm_ack_t NONE = '{1'b0, 1'b0, 1'b0, 8'h00};
  localparam spm_ack_t V40  = '{1'b1, 1'b0, 1'b0, 8'h40};
  localparam spm_ack_t V77  = '{1'b1, 1'b0, 1'b0, 8'h77};
  localparam logic [15:0] RST_VAL [8] = '{`SPM_CFG_RST, `SPM_AVS_RST, `SPM_PROT_RST,
    `SPM_PIC_RST, `SPM_PTR_RST, 16'h0000, `SPM_WVEC_RST, 16'h0000};
  localparam logic [2:0] GLVL [4] = '{3'h0, 3'h3, 3'h7, 3'h3};
  localparam logic [2:0] GREQ [4] = '{3'b011, 3'b011, 3'b011, 3'b111};
  localparam logic [2:0] GEXP [4] = '{3'b001, 3'b010, 3'b001, 3'b100};

  always #50 clk = ~clk;

  // unit under test, short watchdog base for a quick run
  spm_monitors #(.WDT_BASE_LOG(2)) i_spm_monitors (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .EXT_IRQ_I(ext_irq),
    .INTERRUPT_ACKNOWLEDGE_CYCLE_I(interrupt_acknowledge_cycle), .INTERRUPT_ACKNOWLEDGE_CYCLE_LEVEL_I(interrupt_acknowledge_cycle_lvl), .PEER_ARB_I(peer_arb),
    .PEER_ARBITRATION_PRIORITY_FIELD_I(peer_arbitration_priority_field), .IRQ_LEVEL_O(irq_lvl), .ACK_O(ack),
    .BUS_CYC_I(cyc), .BUS_ERR_O(bus_err), .HALT_I(halt), .SYS_RESET_O(sys_rst),
    .SHOW_EN_O(show_en), .SHOW_ARB_EN_O(show_arb), .UNIT_BREQ_I(breq[2]),
    .DMA_BREQ_I(breq[1]), .CORE_BREQ_I(breq[0]), .GRANT_O(grant)
  );

  // core side of the acknowledge bus
  spm_core_model i_spm_core_model (
    .clk_i(clk), .rst_n_i(rst_n), .go_i(go), .lvl_i(go_lvl), .lag_i(lag),
    .ack_i(ack), .interrupt_acknowledge_cycle_o(interrupt_acknowledge_cycle), .interrupt_acknowledge_cycle_lvl_o(interrupt_acknowledge_cycle_lvl), .got_o(got), .done_o(done)
  );

  task automatic tally_and_finish();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_ack(input spm_ack_t g, input spm_ack_t e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t answer %h expected %h", $time, g, e);
    end
  endtask

  // register bus: one-cycle strobes
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk_v(rdata, e);
  endtask

  // one acknowledge cycle through the core model
  task automatic ack_chk(input logic [2:0] l, input spm_ack_t e);
    @(posedge clk);
    go <= 1'b1;
    go_lvl <= l;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk_ack(got, e);
  endtask

  // bounded wait: 0 bus error, 1 system reset, else wanted level
  task automatic wait_for(input int k, input int hi);
    n = 0;
    while (n < hi && (k == 0 ? bus_err : k == 1 ? sys_rst : irq_lvl === want) !== 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic t_regs();
    for (int i = 0; i < 8; i++)
      rd_chk(3'(i), RST_VAL[i]);
    wr_reg(`SPM_OFS_CFG, 16'hffff);
    rd_chk(`SPM_OFS_CFG, `SPM_CFG_MASK);
    wr_reg(`SPM_OFS_RCS, 16'hffff);
    rd_chk(`SPM_OFS_RCS, 16'h0000);
    wr_reg(`SPM_OFS_PTR, 16'h0300);
    rd_chk(`SPM_OFS_PTR, 16'h0300);
    wr_reg(`SPM_OFS_PTR, 16'h0000);
    wr_reg(`SPM_OFS_CFG, 16'h0000);
  endtask

  task automatic t_periodic();
    wr_reg(`SPM_OFS_PIC, 16'h0340);
    wr_reg(`SPM_OFS_PTR, 16'h0002);
    repeat (20) @(posedge clk);
    ack_chk(3'h3, SPUR);
    wr_reg(`SPM_OFS_CFG, 16'h0005);
    want = 3'h3;
    wait_for(2, 30);
    ack_chk(3'h3, V40);
    wr_reg(`SPM_OFS_PTR, 16'h0005);
    wait_for(2, 40);
    chk_v(16'(n < 12), 16'h0001);
    ack_chk(3'h3, V40);
    wait_for(2, 40);
    chk_v(16'(n >= 12 && n < 40), 16'h0001);
    ack_chk(3'h3, V40);
    wr_reg(`SPM_OFS_PTR, 16'h0000);
    wait_for(2, 60);
    chk_v(16'(n), 16'h003c);
    wr_reg(`SPM_OFS_PTR, 16'h0101);
    wait_for(2, 2400);
    chk_v(16'(n < 2100), 16'h0001);
    ack_chk(3'h3, V40);
    // prescaler runs free, so only the second period is a full 2048 clocks
    wait_for(2, 2400);
    chk_v(16'(n >= 2000 && n < 2060), 16'h0001);
    ack_chk(3'h3, V40);
    wr_reg(`SPM_OFS_PTR, 16'h0000);
  endtask

  task automatic t_interrupt_acknowledge_cycle();
    wr_reg(`SPM_OFS_AVS, 16'h0010);
    ext_irq <= 7'h0a;
    peer_arb <= 1'b1;
    peer_arbitration_priority_field <= 4'h2;
    ack_chk(3'h4, AUTO);
    peer_arbitration_priority_field <= 4'hf;
    ack_chk(3'h4, NONE);
    peer_arb <= 1'b0;
    ack_chk(3'h2, NONE);
    ext_irq <= 7'h00;
    lag <= 4'h5;
    ack_chk(3'h6, SPUR);
    lag <= 4'h0;
  endtask

  task automatic t_config();
    wr_reg(`SPM_OFS_CFG, 16'h0015);
    @(negedge clk);
    chk_v({show_en, show_arb}, 16'h0003);
    wr_reg(`SPM_OFS_CFG, 16'h0025);
    @(negedge clk);
    chk_v({show_en, show_arb}, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      wr_reg(`SPM_OFS_CFG, {5'h00, GLVL[i], 8'h05});
      breq <= GREQ[i];
      @(negedge clk);
      chk_v(grant, GEXP[i]);
    end
    @(posedge clk);
    breq <= 3'h0;
  endtask

  task automatic t_monitor();
    // a termination part way through must restart the count
    cyc <= '{1'b1, 1'b0, 1'b1, 1'b0};
    repeat (40) @(posedge clk);
    cyc <= '{1'b1, 1'b0, 1'b1, 1'b1};
    @(posedge clk);
    cyc <= '{1'b1, 1'b0, 1'b1, 1'b0};
    wait_for(0, 100);
    chk_v(16'(n >= 60 && n < 70), 16'h0001);
    // idle one clock between cycles so the one-shot error latch clears
    cyc <= '0;
    @(posedge clk);
    cyc <= '{1'b1, 1'b1, 1'b1, 1'b0};
    wait_for(0, 200);
    chk_v(16'(n), 16'h00c8);
    cyc <= '0;
    wr_reg(`SPM_OFS_PROT, 16'h0005);
    cyc <= '{1'b1, 1'b1, 1'b1, 1'b0};
    wait_for(0, 200);
    chk_v(16'(n >= 120 && n < 135), 16'h0001);
    cyc <= '0;
    @(posedge clk);
    cyc <= '{1'b1, 1'b1, 1'b0, 1'b0};
    wait_for(0, 200);
    chk_v(16'(n), 16'h00c8);
    cyc <= '0;
  endtask

  task automatic t_watchdog();
    wr_reg(`SPM_OFS_WVEC, 16'h0077);
    wr_reg(`SPM_OFS_PROT, 16'h00b0);
    want = 3'h7;
    repeat (3) begin
      wait_for(2, 150);
      chk_v(16'(n), 16'h0096);
      wr_reg(`SPM_OFS_WSV, 16'h0055);
      wr_reg(`SPM_OFS_RCS, 16'h0000);
      wr_reg(`SPM_OFS_WSV, 16'h00aa);
    end
    wait_for(2, 150);
    wr_reg(`SPM_OFS_WSV, 16'h00aa);
    wait_for(2, 200);
    chk_v(16'(n < 120), 16'h0001);
    wr_reg(`SPM_OFS_PIC, 16'h0740);
    wr_reg(`SPM_OFS_PTR, 16'h0001);
    repeat (10) @(posedge clk);
    ack_chk(3'h7, V77);
    ack_chk(3'h7, V40);
    wr_reg(`SPM_OFS_PTR, 16'h0000);
    wr_reg(`SPM_OFS_PROT, 16'h00f0);
    wait_for(1, 300);
    chk_v(16'(n < 300), 16'h0001);
    rd_chk(`SPM_OFS_RCS, 16'h0001);
  endtask

  task automatic t_fault();
    wr_reg(`SPM_OFS_PROT, 16'h0000);
    halt <= 1'b1;
    wait_for(1, 20);
    chk_v(16'(n), 16'h0014);
    halt <= 1'b0;
    wr_reg(`SPM_OFS_PROT, 16'h0008);
    halt <= 1'b1;
    wait_for(1, 4);
    chk_v(16'(n < 4), 16'h0001);
    halt <= 1'b0;
    rd_chk(`SPM_OFS_RCS, 16'h0002);
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_periodic();
    t_interrupt_acknowledge_cycle();
    t_config();
    t_monitor();
    t_watchdog();
    t_fault();
    tally_and_finish();
  end
endmodule
